// file: pkg/sor_pkg.sv
/*
 * Shared constants and carriers for the supported-opcode reporter:
 * command identity, reporting options, descriptor sizes, sense codes,
 * the table of supported commands and the packed CDB and status layouts.
 * Assumes the command block arrives as twelve bytes, byte 0 first.
 */
package sor_pkg;

    // command identity
    localparam logic [7:0] SOR_OPCODE = 8'ha3;
    localparam logic [4:0] SOR_SVC_ACTION = 5'h0c;

    // reporting options
    localparam logic [2:0] SOR_OPT_ALL = 3'h0;
    localparam logic [2:0] SOR_OPT_ONE = 3'h1;
    localparam logic [2:0] SOR_OPT_PAIR = 3'h2;

    // support field codes of a single-command answer
    localparam logic [2:0] SOR_SUP_NONE = 3'h1;
    localparam logic [2:0] SOR_SUP_STD = 3'h3;

    // response layout
    localparam logic [31:0] SOR_HDR_LEN = 32'h4;
    localparam logic [31:0] SOR_DESC_LEN = 32'h8;
    localparam logic [31:0] SOR_DESC_LEN_TD = 32'h14;
    localparam logic [31:0] SOR_TOUT_LEN = 32'hc;
    localparam logic [7:0] SOR_DESC_SA_HI = 8'h2;
    localparam logic [7:0] SOR_DESC_SA_LO = 8'h3;
    localparam logic [7:0] SOR_DESC_FLAGS = 8'h5;
    localparam logic [7:0] SOR_DESC_CDBLEN = 8'h7;
    localparam logic [7:0] SOR_DESC_TOUT = 8'h8;
    localparam logic [7:0] SOR_TOUT_DLEN_LO = 8'h1;
    localparam logic [7:0] SOR_TOUT_DLEN = 8'h0a;
    localparam logic [7:0] SOR_TOUT_NOM = 8'h4;
    localparam logic [7:0] SOR_TOUT_REC = 8'h8;
    localparam logic [7:0] SOR_TOUT_LAST = 8'hb;
    localparam logic [7:0] SOR_USAGE_FULL = 8'hff;

    // sense data for a rejected field
    localparam logic [3:0] SOR_SK_ILLEGAL = 4'h5;
    localparam logic [7:0] SOR_ASC_INV_FIELD = 8'h24;

    // one supported command
    typedef struct packed {
        logic [7:0] opcode;
        logic [15:0] svc_action;
        logic has_sa;
        logic [7:0] cdb_len;
    } sor_entry_t;

    localparam int SOR_NUM_CMDS = 9;
    localparam sor_entry_t SOR_CMD_TABLE [SOR_NUM_CMDS] = '{
        '{8'h00, 16'h0000, 1'b0, 8'h06},
        '{8'h03, 16'h0000, 1'b0, 8'h06},
        '{8'h12, 16'h0000, 1'b0, 8'h06},
        '{8'h28, 16'h0000, 1'b0, 8'h0a},
        '{8'h2a, 16'h0000, 1'b0, 8'h0a},
        '{8'ha0, 16'h0000, 1'b0, 8'h0c},
        '{8'ha3, 16'h0005, 1'b1, 8'h0c},
        '{8'ha3, 16'h000c, 1'b1, 8'h0c},
        '{8'h9e, 16'h0010, 1'b1, 8'h10}
    };

    // command block, byte 0 in the top bits
    typedef struct packed {
        logic [7:0] opcode;
        logic [2:0] rsvd1;
        logic [4:0] svc_action;
        logic return_timeouts_request;
        logic [3:0] rsvd2;
        logic [2:0] option;
        logic [7:0] req_op;
        logic [15:0] req_sa;
        logic [31:0] alloc_len;
        logic [7:0] rsvd10;
        logic [7:0] control;
    } sor_cdb_t;

    // completion status
    typedef struct packed {
        logic check_cond;
        logic [3:0] sense_key;
        logic [7:0] add_sense;
    } sor_status_t;

    typedef enum {SOR_IDLE, SOR_CHECK, SOR_SEND, SOR_FINISH} sor_state_t;

endpackage

// file: src/sor_cmd_table.sv
/*
 * Supported-command table: returns the entry at an index for the list walk
 * and searches by operation code, or by code and service action.
 * Assumes the inputs are held stable by the caller while the answer is used.
 */
module sor_cmd_table
    import sor_pkg::*;
#(
    parameter int IDX_W = 4
) (
    input wire logic [IDX_W-1:0] idx,
    input wire logic [7:0] req_op,
    input wire logic [15:0] req_sa,
    input wire logic use_sa,
    output sor_entry_t idx_entry,
    output logic hit,
    output sor_entry_t hit_entry,
    output logic op_known,
    output logic op_has_sa
);

    // entry for the list walk, zero past the end
    assign idx_entry = (int'(idx) < SOR_NUM_CMDS) ? SOR_CMD_TABLE[idx] : '0;

    // search by code, and by code plus service action when asked
    always_comb begin
        hit = 1'b0;
        hit_entry = '0;
        op_known = 1'b0;
        op_has_sa = 1'b0;
        for (int i = 0; i < SOR_NUM_CMDS; i++) begin
            if (SOR_CMD_TABLE[i].opcode == req_op) begin
                op_known = 1'b1;
                op_has_sa = SOR_CMD_TABLE[i].has_sa;
                if (use_sa ? (SOR_CMD_TABLE[i].has_sa && SOR_CMD_TABLE[i].svc_action == req_sa)
                           : !SOR_CMD_TABLE[i].has_sa) begin
                    hit = 1'b1;
                    hit_entry = SOR_CMD_TABLE[i];
                end
            end
        end
    end

endmodule

// file: src/sor_reporter.sv
/*
 * Target-side handler for the report-supported-operation-codes command:
 * decodes the CDB, rejects bad field combinations, and streams the
 * truncated response one byte per handshake.
 * Assumes the CDB is valid in the cycle cdb_valid is high and that the
 * consumer of data_byte obeys data_valid/data_ready.
 */
// What this block does
// - act only on A3h with service action 0Ch
// - timeouts descriptors only when requested
// - option 000b lists all commands
// - option 001b reports one opcode, ignores SA
// - option 001b on SA opcode is rejected
// - option 010b reports opcode and SA pair
// - option 010b on non-SA opcode is rejected
// - truncate to allocation length without error
// - four-byte header holds length minus four
// - one descriptor per supported command
// - opcode byte 0, SA bytes 2-3, timeouts 8-19
// - SA field zero without service actions
// - byte 5 bit 1 flags timeouts present
// - bytes 6-7 carry the CDB length
// - support field 001b unsupported, 011b standard
// - timeouts descriptor starts with length 0Ah
module sor_reporter
    import sor_pkg::*;
#(
    parameter logic [31:0] NOMINAL_TIMEOUT = 32'h0,
    parameter logic [31:0] RECOMMENDED_TIMEOUT = 32'h0,
    parameter int IDX_W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cdb_valid,
    input wire sor_cdb_t cdb,
    input wire logic data_ready,
    output logic busy,
    output logic data_valid,
    output logic [7:0] data_byte,
    output logic data_last,
    output logic done,
    output sor_status_t status
);

    sor_state_t state;
    sor_cdb_t req;
    logic [31:0] pos;
    logic [31:0] limit;
    logic [IDX_W-1:0] desc_idx;
    logic [7:0] desc_off;
    logic err;

    sor_entry_t idx_entry;
    sor_entry_t hit_entry;
    logic hit;
    logic op_known;
    logic op_has_sa;

    // timeouts descriptor byte k
    function automatic logic [7:0] tout_byte(input logic [7:0] k);
        int sh;
        sh = 0;
        if (k == SOR_TOUT_DLEN_LO)
            return SOR_TOUT_DLEN;
        if (k >= SOR_TOUT_NOM && k < SOR_TOUT_REC) begin
            sh = (int'(SOR_TOUT_REC) - 1 - int'(k)) * 8;
            return 8'(NOMINAL_TIMEOUT >> sh);
        end
        if (k >= SOR_TOUT_REC && k <= SOR_TOUT_LAST) begin
            sh = (int'(SOR_TOUT_LAST) - int'(k)) * 8;
            return 8'(RECOMMENDED_TIMEOUT >> sh);
        end
        return 8'h00;
    endfunction

    // command descriptor byte at offset off
    function automatic logic [7:0] desc_byte(input sor_entry_t e, input logic [7:0] off, input logic td);
        case (off)
            8'h0: return e.opcode;
            SOR_DESC_SA_HI: return e.has_sa ? e.svc_action[15:8] : 8'h00;
            SOR_DESC_SA_LO: return e.has_sa ? e.svc_action[7:0] : 8'h00;
            SOR_DESC_FLAGS: return {6'h00, td, e.has_sa};
            SOR_DESC_CDBLEN: return e.cdb_len;
            default: return (td && off >= SOR_DESC_TOUT) ? tout_byte(8'(off - SOR_DESC_TOUT)) : 8'h00;
        endcase
    endfunction

    sor_cmd_table #(.IDX_W(IDX_W)) u_table (
        .idx(desc_idx),
        .req_op(req.req_op),
        .req_sa(req.req_sa),
        .use_sa(req.option == SOR_OPT_PAIR),
        .idx_entry(idx_entry),
        .hit(hit),
        .hit_entry(hit_entry),
        .op_known(op_known),
        .op_has_sa(op_has_sa)
    );

    // request decode and checks
    wire cmd_match = cdb.opcode == SOR_OPCODE && cdb.svc_action == SOR_SVC_ACTION;
    wire accept = ce && state == SOR_IDLE && cdb_valid && cmd_match;
    wire want_tout = req.return_timeouts_request;
    wire all_mode = req.option == SOR_OPT_ALL;
    wire bad_opt = req.option > SOR_OPT_PAIR;
    wire bad_one = req.option == SOR_OPT_ONE && op_known && op_has_sa;
    wire bad_pair = req.option == SOR_OPT_PAIR && op_known && !op_has_sa;
    wire check_fail = bad_opt || bad_one || bad_pair;

    // response lengths; single-command answers use the table hit
    wire one_td = want_tout && hit;
    wire [31:0] desc_len = want_tout ? SOR_DESC_LEN_TD : SOR_DESC_LEN;
    wire [31:0] total_all = SOR_HDR_LEN + 32'(SOR_NUM_CMDS) * desc_len;
    wire [31:0] total_one = hit ? SOR_HDR_LEN + 32'(hit_entry.cdb_len) + (one_td ? SOR_TOUT_LEN : 32'h0)
                                : SOR_HDR_LEN;
    wire [31:0] total = all_mode ? total_all : total_one;
    wire [31:0] next_limit = (total < req.alloc_len) ? total : req.alloc_len;
    wire [31:0] data_len = total - SOR_HDR_LEN;

    // byte at the current position
    wire [31:0] usage_pos = pos - SOR_HDR_LEN;
    wire [31:0] tout_pos = usage_pos - 32'(hit_entry.cdb_len);
    wire [7:0] hdr_byte = 8'(data_len >> ((SOR_HDR_LEN - 32'h1 - pos) * 32'h8));
    wire [7:0] usage_byte = (usage_pos == 32'h0) ? hit_entry.opcode :
                            (usage_pos == 32'h1 && hit_entry.has_sa) ? {3'h7, hit_entry.svc_action[4:0]} :
                            SOR_USAGE_FULL;
    wire [7:0] one_byte = (pos == 32'h1) ? {one_td, 4'h0, hit ? SOR_SUP_STD : SOR_SUP_NONE} :
                          (pos == 32'h3) ? (hit ? hit_entry.cdb_len : 8'h00) :
                          (pos < SOR_HDR_LEN) ? 8'h00 :
                          (usage_pos < 32'(hit_entry.cdb_len)) ? usage_byte :
                          tout_byte(tout_pos[7:0]);
    wire [7:0] cur_byte = !all_mode ? one_byte :
                          (pos < SOR_HDR_LEN) ? hdr_byte : desc_byte(idx_entry, desc_off, want_tout);

    // output handshake
    wire slot_free = !data_valid || data_ready;
    wire load = ce && state == SOR_SEND && slot_free;
    wire is_last = pos == limit - 32'h1;
    wire desc_end = 32'(desc_off) == desc_len - 32'h1;

    // control state machine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= SOR_IDLE;
            req <= '0;
            err <= 1'b0;
            limit <= 32'h0;
        end else if (ce) begin
            case (state)
                SOR_IDLE: if (accept) begin
                    req <= cdb;
                    state <= SOR_CHECK;
                end
                SOR_CHECK: begin
                    err <= check_fail;
                    limit <= next_limit;
                    state <= (check_fail || next_limit == 32'h0) ? SOR_FINISH : SOR_SEND;
                end
                SOR_SEND: if (load && is_last) state <= SOR_FINISH;
                SOR_FINISH: if (!data_valid) state <= SOR_IDLE;
                default: state <= SOR_IDLE;
            endcase
        end
    end

    // position and descriptor walk
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos <= 32'h0;
            desc_idx <= '0;
            desc_off <= 8'h0;
        end else if (ce) begin
            if (state == SOR_CHECK) begin
                pos <= 32'h0;
                desc_idx <= '0;
                desc_off <= 8'h0;
            end else if (load) begin
                pos <= pos + 32'h1;
                if (pos >= SOR_HDR_LEN) begin
                    desc_off <= desc_end ? 8'h0 : desc_off + 8'h1;
                    if (desc_end) desc_idx <= desc_idx + 1'b1;
                end
            end
        end
    end

    // data byte register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_valid <= 1'b0;
            data_byte <= 8'h00;
            data_last <= 1'b0;
        end else if (ce) begin
            if (load) begin
                data_valid <= 1'b1;
                data_byte <= cur_byte;
                data_last <= is_last;
            end else if (data_ready) begin
                data_valid <= 1'b0;
                data_last <= 1'b0;
            end
        end
    end

    // completion and sense report; truncation never raises an error
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            status <= '0;
        end else if (ce) begin
            done <= 1'b0;
            if (accept) busy <= 1'b1;
            if (state == SOR_FINISH && !data_valid) begin
                busy <= 1'b0;
                done <= 1'b1;
                status <= err ? '{1'b1, SOR_SK_ILLEGAL, SOR_ASC_INV_FIELD} : '0;
            end
        end
    end

    chk_cmd_ignore: assert property (@(posedge clk) disable iff (rst)
        (ce && state == SOR_IDLE && cdb_valid && !cmd_match) |=> state == SOR_IDLE)
        else $error("foreign command was taken");
    chk_reserved_opt: assert property (@(posedge clk) disable iff (rst)
        (accept && cdb.option > SOR_OPT_PAIR) |-> ##[2:8] (done && status.check_cond))
        else $error("reserved option not rejected");
    chk_one_sa_reject: assert property (@(posedge clk) disable iff (rst)
        (ce && state == SOR_CHECK && bad_one) |-> ##[1:6] (done && status.sense_key == SOR_SK_ILLEGAL))
        else $error("option one on service action code not rejected");
    chk_pair_reject: assert property (@(posedge clk) disable iff (rst)
        (ce && state == SOR_CHECK && bad_pair) |-> ##[1:6] (done && status.add_sense == SOR_ASC_INV_FIELD))
        else $error("option two on plain code not rejected");
    chk_trunc_limit: assert property (@(posedge clk) disable iff (rst)
        (load && is_last) |-> (pos < req.alloc_len && pos < total))
        else $error("byte sent past allocation length");
    chk_hdr_length: assert property (@(posedge clk) disable iff (rst)
        (load && all_mode && pos == 32'h3) |=> data_byte == $past(data_len[7:0]))
        else $error("header length byte wrong");
    chk_flags_byte: assert property (@(posedge clk) disable iff (rst)
        (load && all_mode && pos >= SOR_HDR_LEN && desc_off == SOR_DESC_FLAGS)
        |=> data_byte == {6'h00, $past(want_tout), $past(idx_entry.has_sa)})
        else $error("descriptor flag byte wrong");
    chk_sa_zero: assert property (@(posedge clk) disable iff (rst)
        (load && all_mode && pos >= SOR_HDR_LEN && !idx_entry.has_sa &&
         (desc_off == SOR_DESC_SA_HI || desc_off == SOR_DESC_SA_LO)) |=> data_byte == 8'h00)
        else $error("service action not zero");
    chk_tout_len: assert property (@(posedge clk) disable iff (rst)
        (load && all_mode && pos >= SOR_HDR_LEN && want_tout && desc_off == SOR_DESC_TOUT + SOR_TOUT_DLEN_LO)
        |=> data_byte == SOR_TOUT_DLEN)
        else $error("timeouts length byte wrong");
    chk_no_tout: assert property (@(posedge clk) disable iff (rst)
        (state == SOR_SEND && all_mode && !want_tout) |-> total == SOR_HDR_LEN + 32'(SOR_NUM_CMDS) * SOR_DESC_LEN)
        else $error("timeouts present without request");

endmodule

// file: tb/sor_initiator_model.sv
/*
 * Initiator-side consumer of the response stream: takes bytes on
 * valid/ready, records them with the index of the final byte.
 * Assumes one clock and the stream handshake of the reporter.
 */
module sor_initiator_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic slow,
    input wire logic data_valid,
    input wire logic [7:0] data_byte,
    input wire logic data_last,
    output logic data_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    int count;
    int last_at;

    // ready changes only after an edge; slow mode stalls every other cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_ready <= 1'b0;
            count <= 0;
            last_at <= -1;
        end else begin
            data_ready <= slow ? ~data_ready : 1'b1;
            if (clr) begin
                count <= 0;
                last_at <= -1;
            end else if (data_valid && data_ready) begin
                mem[count] <= data_byte;
                count <= count + 1;
                if (data_last) last_at <= count;
            end
        end
    end
endmodule

// file: tb/sor_reporter_tb.sv
/*
 * Self-checking bench of the supported-opcode reporter: run_cmd issues
 * one command and compares the streamed answer and status.
 * Assumes the initiator model in sor_initiator_model.sv.
 */
module sor_reporter_tb
    import sor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
    localparam logic [31:0] NOM = 32'h11223344;
    localparam logic [31:0] REC = 32'h55667788;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cdb_valid = 1'b0;
    sor_cdb_t cdb = '0;
    logic clr = 1'b0;
    logic slow = 1'b0;
    logic ce = 1'b1;
    logic data_ready, busy, data_valid, data_last, done;
    logic [7:0] data_byte;
    sor_status_t status;
    int fails = 0;
    int num_checks = 0;
    logic [7:0] exp [0:255];
    int ne;

    sor_reporter #(.NOMINAL_TIMEOUT(NOM), .RECOMMENDED_TIMEOUT(REC)) sor_reporter_i (
        .clk(clk), .rst(rst), .ce(ce), .cdb_valid(cdb_valid), .cdb(cdb),
        .data_ready(data_ready), .busy(busy), .data_valid(data_valid),
        .data_byte(data_byte), .data_last(data_last), .done(done), .status(status));
    sor_initiator_model sor_initiator_model_i (
        .clk(clk), .rst(rst), .clr(clr), .slow(slow), .data_valid(data_valid),
        .data_byte(data_byte), .data_last(data_last), .data_ready(data_ready));

    // free-running clock
    always #5 clk = ~clk;

    function automatic sor_cdb_t mk(input logic [2:0] opt, input logic want_tout,
        input logic [7:0] rop, input logic [15:0] rsa, input logic [31:0] alen);
        sor_cdb_t c;
        c = '0;
        c.opcode = SOR_OPCODE;
        c.svc_action = SOR_SVC_ACTION;
        c.option = opt;
        c.return_timeouts_request = want_tout;
        c.req_op = rop;
        c.req_sa = rsa;
        c.alloc_len = alen;
        return c;
    endfunction

    task automatic put(input logic [7:0] b);
        exp[ne] = b;
        ne++;
    endtask
    task automatic put4(input logic [31:0] v);
        put(v[31:24]); put(v[23:16]); put(v[15:8]); put(v[7:0]);
    endtask
    task automatic put_tout();
        put(8'h00); put(SOR_TOUT_DLEN); put(8'h00); put(8'h00);
        put4(NOM); put4(REC);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic run_cmd(input sor_cdb_t c, input int n, input logic err);
        int k;
        @(negedge clk);
        clr = 1'b1; cdb = c; cdb_valid = 1'b1;
        @(negedge clk);
        clr = 1'b0; cdb_valid = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        `CHK("done", 1'b1, done)
        `CHK("check_cond", err, status.check_cond)
        `CHK("sense_key", err ? SOR_SK_ILLEGAL : 4'h0, status.sense_key)
        `CHK("add_sense", err ? SOR_ASC_INV_FIELD : 8'h00, status.add_sense)
        `CHK("count", n, sor_initiator_model_i.count)
        for (int i = 0; i < n; i++) `CHK("byte", exp[i], sor_initiator_model_i.mem[i])
        if (n > 0) `CHK("last_at", n - 1, sor_initiator_model_i.last_at)
    endtask

    task automatic t_all(input logic want_tout, input logic [31:0] alen, input int n);
        ne = 0;
        put4(SOR_HDR_LEN * 0 + SOR_NUM_CMDS * (want_tout ? SOR_DESC_LEN_TD : SOR_DESC_LEN));
        for (int i = 0; i < SOR_NUM_CMDS; i++) begin
            put(SOR_CMD_TABLE[i].opcode); put(8'h00);
            put4({SOR_CMD_TABLE[i].has_sa ? SOR_CMD_TABLE[i].svc_action : 16'h0, 8'h00,
                6'h0, want_tout, SOR_CMD_TABLE[i].has_sa});
            put(8'h00); put(SOR_CMD_TABLE[i].cdb_len);
            if (want_tout) put_tout();
        end
        run_cmd(mk(SOR_OPT_ALL, want_tout, 8'h55, 16'hbeef, alen), n, 1'b0);
    endtask

    // a low clock enable must freeze a command in flight, then let it finish
    task automatic t_ce();
        int k;
        @(negedge clk);
        cdb = mk(3'h7, 1'b0, 8'h28, 16'h0, 32'h100);
        cdb_valid = 1'b1;
        @(negedge clk);
        cdb_valid = 1'b0;
        ce = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("busy_frozen", 1'b1, busy)
        `CHK("done_frozen", 1'b0, done)
        ce = 1'b1;
        k = 0;
        while (done !== 1'b1 && k < 10) begin
            @(negedge clk);
            k++;
        end
        `CHK("done", 1'b1, done)
        `CHK("check_cond", 1'b1, status.check_cond)
    endtask

    task automatic t_errors();
        ne = 0;
        run_cmd(mk(SOR_OPT_ONE, 1'b0, 8'ha3, 16'h0, 32'h100), 0, 1'b1);
        run_cmd(mk(SOR_OPT_PAIR, 1'b0, 8'h28, 16'h0, 32'h100), 0, 1'b1);
        for (int o = 3; o < 8; o++) run_cmd(mk(o[2:0], 1'b0, 8'h28, 16'h0, 32'h100), 0, 1'b1);
        run_cmd(mk(SOR_OPT_ALL, 1'b0, 8'h0, 16'h0, 32'h0), 0, 1'b0);
    endtask

    task automatic t_one();
        ne = 0;
        put(8'h00); put({1'b1, 4'h0, SOR_SUP_STD}); put(8'h00); put(8'h0a); put(8'h28);
        for (int i = 0; i < 9; i++) put(8'hff);
        put_tout();
        run_cmd(mk(SOR_OPT_ONE, 1'b1, 8'h28, 16'h1234, 32'h100), 26, 1'b0);
        ne = 0;
        put(8'h00); put({5'h0, SOR_SUP_NONE}); put(8'h00); put(8'h00);
        run_cmd(mk(SOR_OPT_ONE, 1'b0, 8'h55, 16'h0, 32'h100), 4, 1'b0);
    endtask

    task automatic t_pair();
        ne = 0;
        put(8'h00); put({5'h0, SOR_SUP_STD}); put(8'h00); put(8'h10); put(8'h9e); put(8'hf0);
        for (int i = 0; i < 14; i++) put(8'hff);
        run_cmd(mk(SOR_OPT_PAIR, 1'b0, 8'h9e, 16'h0010, 32'h100), 20, 1'b0);
    endtask

    task automatic t_foreign();
        sor_cdb_t c;
        c = mk(SOR_OPT_ALL, 1'b0, 8'h0, 16'h0, 32'h100);
        c.opcode = 8'h12;
        @(negedge clk);
        cdb = c; cdb_valid = 1'b1;
        @(negedge clk);
        cdb_valid = 1'b0;
        repeat (5) begin
            @(negedge clk);
            `CHK("busy", 1'b0, busy)
            `CHK("done", 1'b0, done)
        end
    endtask

    // watchdog against a hung handshake
    initial begin
        #200000;
        fails++;
        stop_test();
    end

    // main sequence
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_foreign();
        t_ce();
        t_all(1'b0, 32'h100, 76);
        slow = 1'b1;
        t_all(1'b1, 32'h100, 184);
        slow = 1'b0;
        t_all(1'b0, 32'ha, 10);
        t_errors();
        t_one();
        t_pair();
        stop_test();
    end
endmodule
